// >>> logic/tei_pkg.sv
// Constants and types for the time-stamp event input register bank
// Functional notes
// R01 - Writing the seconds alias updates seconds but keeps the sub-second count running.
// R02 - Seconds alias reads and writes reach the same seconds counter as primary.
// R03 - Minutes and hours aliases reach the same counters as their primary addresses.
// R04 - Counter_a and day aliases reach the same counters as their primary addresses.
// R05 - Month and year aliases reach the same counters as their primary addresses.
// R06 - Buffer mode select 1 means direct mode, 0 means FIFO mode.
// R07 - A trigger captures a time stamp only when that input's capture enable is 1.
// R08 - Capture enable has no effect unless the same input's pin enable is 1.
// R09 - Triggers are accepted on an input only while its pin enable is 1.
// R10 - Bias field: 000 none, 001/010/011 pull-ups, 100 pull-down, others none.
// R11 - Edge field: 00 falling, 01 rising, 10 or 11 both edges.
// R12 - Each input configuration register resets to 1M pull-up, falling edge, 0x08.
// R13 - Writing the primary seconds address clears the sub-second counter.
// R14 - Consecutive addresses let sub-second then alias registers be accessed in sequence.
// R15 - Reserved and unused bits read zero and ignore writes.
// R16 - Inputs are synchronised before edge detection, one trigger per edge.
`default_nettype none
package tei_pkg;

  localparam int ADDR_W   = 12;
  localparam int IDX_LSB  = 2;
  localparam int IDX_MSB  = 8;
  localparam int NUM_PINS = 3;

  // Register indexes; byte address is four times the index
  localparam logic [6:0] IDX_SEC      = 7'h00;
  localparam logic [6:0] IDX_MIN      = 7'h01;
  localparam logic [6:0] IDX_HOUR     = 7'h02;
  localparam logic [6:0] IDX_WEEK     = 7'h03;
  localparam logic [6:0] IDX_DAY      = 7'h04;
  localparam logic [6:0] IDX_MONTH    = 7'h05;
  localparam logic [6:0] IDX_YEAR     = 7'h06;
  localparam logic [6:0] IDX_SUB_LO   = 7'h10;
  localparam logic [6:0] IDX_SUB_HI   = 7'h11;
  localparam logic [6:0] IDX_SEC_AL   = 7'h12;
  localparam logic [6:0] IDX_MIN_AL   = 7'h13;
  localparam logic [6:0] IDX_HOUR_AL  = 7'h14;
  localparam logic [6:0] IDX_WEEK_AL  = 7'h15;
  localparam logic [6:0] IDX_DAY_AL   = 7'h16;
  localparam logic [6:0] IDX_MONTH_AL = 7'h17;
  localparam logic [6:0] IDX_YEAR_AL  = 7'h18;
  localparam logic [6:0] IDX_EN       = 7'h20;
  localparam logic [6:0] IDX_CFG1     = 7'h21;
  localparam logic [6:0] IDX_CFG2     = 7'h23;
  localparam logic [6:0] IDX_CFG3     = 7'h25;

  // Writable-bit masks
  localparam logic [7:0] MASK_SEC    = 8'h7f;
  localparam logic [7:0] MASK_MIN    = 8'h7f;
  localparam logic [7:0] MASK_HOUR   = 8'h3f;
  localparam logic [7:0] MASK_WEEK   = 8'h7f;
  localparam logic [7:0] MASK_DAY    = 8'h3f;
  localparam logic [7:0] MASK_MONTH  = 8'h1f;
  localparam logic [7:0] MASK_YEAR   = 8'hff;
  localparam logic [7:0] MASK_EN     = 8'h7f;
  localparam logic [7:0] MASK_CFG    = 8'h1f;

  localparam logic [7:0] TIME_RESET  = 8'h00;
  localparam logic [7:0] EN_RESET    = 8'h00;
  localparam logic [7:0] CFG_RESET   = 8'h08;

  localparam int EN_PIN_LSB = 0;
  localparam int EN_CAP_LSB = 3;
  localparam int EN_DIR_BIT = 6;
  localparam int CFG_EDGE_LSB = 0;
  localparam int CFG_EDGE_MSB = 1;
  localparam int CFG_BIAS_LSB = 2;
  localparam int CFG_BIAS_MSB = 4;

  localparam logic [2:0] BIAS_NONE     = 3'h0;
  localparam logic [2:0] BIAS_PU_500K  = 3'h1;
  localparam logic [2:0] BIAS_PU_1M    = 3'h2;
  localparam logic [2:0] BIAS_PU_10M   = 3'h3;
  localparam logic [2:0] BIAS_PD_500K  = 3'h4;
  localparam logic [1:0] EDGE_FALL     = 2'h0;
  localparam logic [1:0] EDGE_RISE     = 2'h1;

  localparam int         FRAC_W      = 10;
  localparam int         SUBLO_LSB   = 6;
  localparam logic [9:0] FRAC_ZERO   = 10'h000;
  localparam logic [9:0] FRAC_MAX    = 10'h3ff;
  localparam logic [3:0] BCD_NINE    = 4'h9;
  localparam logic [3:0] BCD_FIVE    = 4'h5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int CLOCK_HZ      = 250_000_000;
  localparam int FRAC_HZ       = 1024;
  localparam int FRAC_CYCLES   = CLOCK_HZ / FRAC_HZ;
  localparam int TICK_W        = 18;

  typedef enum logic {RD_IDLE, RD_DATA} tei_rd_state_t;

endpackage : tei_pkg
`default_nettype wire

// >>> logic/tei_event_input.sv
// One event trigger input: synchroniser, edge select and enable gating
`timescale 1ns/10ps
`default_nettype none
module tei_event_input
  import tei_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       event_trigger_pin,
  input  wire logic       event_pin_enable,
  input  wire logic       event_capture_enable,
  input  wire logic [1:0] edge_polarity_select,
  output logic            trigger,
  output logic            capture
);

  logic sync_a;
  logic sync_b;
  logic sync_prev;
  logic next_trigger;
  logic next_capture;
  logic rise;
  logic fall;
  logic hit;

  always_comb begin
    rise = sync_b & ~sync_prev;
    fall = ~sync_b & sync_prev;
    case (edge_polarity_select)
      EDGE_FALL: hit = fall;                                // [R11]
      EDGE_RISE: hit = rise;                                // [R11]
      default:  hit = rise | fall;                          // [R11]
    endcase
    next_trigger = event_pin_enable & hit;                  // [R09]
    next_capture = next_trigger & event_capture_enable;     // [R07] [R08]
  end

  // Idle high matches the default pull-up, so no false edge after reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_a    <= 1'b1;
      sync_b    <= 1'b1;
      sync_prev <= 1'b1;
      trigger   <= 1'b0;
      capture   <= 1'b0;
    end else begin
      sync_a    <= event_trigger_pin;                       // [R16]
      sync_b    <= sync_a;                                  // [R16]
      sync_prev <= sync_b;
      trigger   <= next_trigger;
      capture   <= next_capture;
    end
  end

endmodule : tei_event_input
`default_nettype wire

// >>> logic/tei_regs.sv
// Clock alias and event input configuration registers on AXI4-Lite
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module tei_regs
  import tei_pkg::*;
#(
  parameter int FRAC_TICK_CYCLES = FRAC_CYCLES
)
(
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic [NUM_PINS-1:0] event_trigger_pin,
  output logic [NUM_PINS-1:0]      event_trigger,
  output logic [NUM_PINS-1:0]      capture_strobe,
  output logic                     buffer_mode_select,
  output logic [NUM_PINS-1:0]      pull_up_500k,
  output logic [NUM_PINS-1:0]      pull_up_1m,
  output logic [NUM_PINS-1:0]      pull_up_10m,
  output logic [NUM_PINS-1:0]      pull_down_500k
);

  // Write channel state
  logic                aw_held;
  logic [6:0]          aw_idx;
  logic                aw_ok;
  logic                w_held;
  logic [7:0]          w_byte;
  logic                w_lane;
  logic                next_aw_held;
  logic [6:0]          next_aw_idx;
  logic                next_aw_ok;
  logic                next_w_held;
  logic [7:0]          next_w_byte;
  logic                next_w_lane;
  logic                next_bvalid;
  logic [1:0]          next_bresp;
  logic                do_write;

  // Read channel state
  tei_rd_state_t       rd_state;
  tei_rd_state_t       next_rd_state;
  logic [31:0]         next_rdata;
  logic [1:0]          next_rresp;
  logic [6:0]          ar_idx;
  logic                ar_ok;

  // Register and counter state
  logic [7:0]          seconds_counter;
  logic [7:0]          minutes;
  logic [7:0]          hours;
  logic [7:0]          counter_a;
  logic [7:0]          day;
  logic [7:0]          month;
  logic [7:0]          year;
  logic [9:0]          subsecond_count;
  logic [TICK_W-1:0]   tick_count;
  logic [7:0]          enables;
  logic [7:0]          cfg [NUM_PINS];
  logic [7:0]          next_seconds_counter;
  logic [7:0]          next_minutes;
  logic [7:0]          next_hours;
  logic [7:0]          next_counter_a;
  logic [7:0]          next_day;
  logic [7:0]          next_month;
  logic [7:0]          next_year;
  logic [9:0]          next_subsecond_count;
  logic [TICK_W-1:0]   next_tick_count;
  logic [7:0]          next_enables;
  logic [7:0]          next_cfg [NUM_PINS];
  logic                wr_en;
  logic [7:0]          wr_data;
  logic                tick;

  localparam logic [TICK_W-1:0] TICK_LAST =
    TICK_W'(FRAC_TICK_CYCLES - 1);

  function automatic logic idx_mapped(input logic [6:0] idx);
    case (idx)
      IDX_SEC, IDX_MIN, IDX_HOUR, IDX_WEEK, IDX_DAY, IDX_MONTH, IDX_YEAR,
      IDX_SUB_LO, IDX_SUB_HI, IDX_SEC_AL, IDX_MIN_AL, IDX_HOUR_AL,
      IDX_WEEK_AL, IDX_DAY_AL, IDX_MONTH_AL, IDX_YEAR_AL,
      IDX_EN, IDX_CFG1, IDX_CFG2, IDX_CFG3: idx_mapped = 1'b1;
      default:                             idx_mapped = 1'b0;
    endcase
  endfunction : idx_mapped

  // BCD seconds step 00..59; wraps to 00
  function automatic logic [7:0] sec_step(input logic [7:0] sec);
    logic [3:0] lo;
    logic [3:0] hi;
    lo = sec[3:0];
    hi = sec[7:4];
    if (lo >= BCD_NINE) begin
      lo = 4'h0;
      hi = (hi >= BCD_FIVE) ? 4'h0 : hi + 4'h1;
    end else begin
      lo = lo + 4'h1;
    end
    sec_step = {hi, lo};
  endfunction : sec_step

  // ---------------- AXI write path ----------------
  assign s_axi_awready = ~aw_held;
  assign s_axi_wready  = ~w_held;
  assign do_write      = aw_held & w_held & ~s_axi_bvalid;

  always_comb begin
    next_aw_held = aw_held;
    next_aw_idx  = aw_idx;
    next_aw_ok   = aw_ok;
    next_w_held  = w_held;
    next_w_byte  = w_byte;
    next_w_lane  = w_lane;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    // Address and data are taken in either order
    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_idx  = s_axi_awaddr[IDX_MSB:IDX_LSB];
      next_aw_ok   = (s_axi_awaddr[ADDR_W-1:IDX_MSB+1] == '0) &&
                     idx_mapped(s_axi_awaddr[IDX_MSB:IDX_LSB]);
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_w_byte = s_axi_wdata[7:0];
      next_w_lane = s_axi_wstrb[0];
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = aw_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid  = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aw_held      <= 1'b0;
      aw_idx       <= '0;
      aw_ok        <= 1'b0;
      w_held       <= 1'b0;
      w_byte       <= '0;
      w_lane       <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      aw_held      <= next_aw_held;
      aw_idx       <= next_aw_idx;
      aw_ok        <= next_aw_ok;
      w_held       <= next_w_held;
      w_byte       <= next_w_byte;
      w_lane       <= next_w_lane;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
    end
  end

  // ---------------- AXI read path ----------------
  assign s_axi_arready = (rd_state == RD_IDLE);
  assign s_axi_rvalid  = (rd_state == RD_DATA);
  assign ar_idx        = s_axi_araddr[IDX_MSB:IDX_LSB];
  assign ar_ok         = (s_axi_araddr[ADDR_W-1:IDX_MSB+1] == '0) &&
                         idx_mapped(ar_idx);

  always_comb begin
    next_rd_state = rd_state;
    next_rdata    = s_axi_rdata;
    next_rresp    = s_axi_rresp;
    case (rd_state)
      RD_IDLE: begin
        if (s_axi_arvalid) begin
          next_rd_state = RD_DATA;
          next_rresp    = ar_ok ? RESP_OKAY : RESP_SLVERR;
          next_rdata    = '0;                               // [R15]
          // Primary and alias indexes decode to the same storage
          case (ar_idx)
            IDX_SEC, IDX_SEC_AL:     next_rdata[7:0] = seconds_counter; // [R02]
            IDX_MIN, IDX_MIN_AL:     next_rdata[7:0] = minutes;   // [R03]
            IDX_HOUR, IDX_HOUR_AL:   next_rdata[7:0] = hours;     // [R03]
            IDX_WEEK, IDX_WEEK_AL:   next_rdata[7:0] = counter_a; // [R04]
            IDX_DAY, IDX_DAY_AL:     next_rdata[7:0] = day;       // [R04]
            IDX_MONTH, IDX_MONTH_AL: next_rdata[7:0] = month;     // [R05]
            IDX_YEAR, IDX_YEAR_AL:   next_rdata[7:0] = year;      // [R05]
            IDX_SUB_LO:
              next_rdata[7:SUBLO_LSB] = subsecond_count[1:0];     // [R14]
            IDX_SUB_HI:
              next_rdata[7:0] = subsecond_count[FRAC_W-1:2];      // [R14]
            IDX_EN:   next_rdata[7:0] = enables;
            IDX_CFG1: next_rdata[7:0] = cfg[0];
            IDX_CFG2: next_rdata[7:0] = cfg[1];
            IDX_CFG3: next_rdata[7:0] = cfg[2];
            default:  next_rdata = '0;
          endcase
        end
      end
      RD_DATA: begin
        if (s_axi_rready) begin
          next_rd_state = RD_IDLE;
        end
      end
      default: next_rd_state = RD_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_state    <= RD_IDLE;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      rd_state    <= next_rd_state;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // ---------------- Registers and time base ----------------
  assign wr_en   = do_write & aw_ok & w_lane;
  assign wr_data = w_byte;
  assign tick    = (tick_count == TICK_LAST);

  always_comb begin
    next_seconds_counter = seconds_counter;
    next_minutes         = minutes;
    next_hours           = hours;
    next_counter_a       = counter_a;
    next_day             = day;
    next_month           = month;
    next_year            = year;
    next_enables         = enables;
    next_cfg             = cfg;
    next_tick_count      = tick ? '0 : tick_count + TICK_W'(1);
    next_subsecond_count = subsecond_count;
    if (tick) begin
      next_subsecond_count = subsecond_count + FRAC_W'(1);
      if (subsecond_count == FRAC_MAX) begin
        next_seconds_counter = sec_step(seconds_counter);
      end
    end
    // A software write overrides the running count in the same cycle
    if (wr_en) begin
      case (aw_idx)
        IDX_SEC: begin
          next_seconds_counter = wr_data & MASK_SEC;          // [R02] [R15]
          next_subsecond_count = FRAC_ZERO;                   // [R13]
          next_tick_count      = '0;                          // [R13]
        end
        // Alias write leaves the sub-second phase untouched
        IDX_SEC_AL: next_seconds_counter = wr_data & MASK_SEC;  // [R01] [R02]
        IDX_MIN, IDX_MIN_AL:     next_minutes   = wr_data & MASK_MIN;   // [R03]
        IDX_HOUR, IDX_HOUR_AL:   next_hours     = wr_data & MASK_HOUR;  // [R03]
        IDX_WEEK, IDX_WEEK_AL:   next_counter_a = wr_data & MASK_WEEK;  // [R04]
        IDX_DAY, IDX_DAY_AL:     next_day       = wr_data & MASK_DAY;   // [R04]
        IDX_MONTH, IDX_MONTH_AL: next_month     = wr_data & MASK_MONTH; // [R05]
        IDX_YEAR, IDX_YEAR_AL:   next_year      = wr_data & MASK_YEAR;  // [R05]
        IDX_SUB_LO:
          next_subsecond_count[1:0] = wr_data[7:SUBLO_LSB];   // [R14]
        IDX_SUB_HI:
          next_subsecond_count[FRAC_W-1:2] = wr_data;         // [R14]
        IDX_EN:   next_enables = wr_data & MASK_EN;           // [R15]
        IDX_CFG1: next_cfg[0]  = wr_data & MASK_CFG;          // [R15]
        IDX_CFG2: next_cfg[1]  = wr_data & MASK_CFG;
        IDX_CFG3: next_cfg[2]  = wr_data & MASK_CFG;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      seconds_counter <= TIME_RESET;
      minutes         <= TIME_RESET;
      hours           <= TIME_RESET;
      counter_a       <= TIME_RESET;
      day             <= TIME_RESET;
      month           <= TIME_RESET;
      year            <= TIME_RESET;
      subsecond_count <= FRAC_ZERO;
      tick_count      <= '0;
      enables         <= EN_RESET;
      for (int i = 0; i < NUM_PINS; i++) begin
        cfg[i] <= CFG_RESET;                                  // [R12]
      end
    end else begin
      seconds_counter <= next_seconds_counter;
      minutes         <= next_minutes;
      hours           <= next_hours;
      counter_a       <= next_counter_a;
      day             <= next_day;
      month           <= next_month;
      year            <= next_year;
      subsecond_count <= next_subsecond_count;
      tick_count      <= next_tick_count;
      enables         <= next_enables;
      cfg             <= next_cfg;
    end
  end

  // ---------------- Pin configuration outputs ----------------
  assign buffer_mode_select = enables[EN_DIR_BIT];            // [R06]

  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      pull_up_500k[i]   = 1'b0;
      pull_up_1m[i]     = 1'b0;
      pull_up_10m[i]    = 1'b0;
      pull_down_500k[i] = 1'b0;
      // Unlisted codes fall through to no bias
      case (cfg[i][CFG_BIAS_MSB:CFG_BIAS_LSB])
        BIAS_PU_500K: pull_up_500k[i]   = 1'b1;               // [R10]
        BIAS_PU_1M:   pull_up_1m[i]     = 1'b1;               // [R10]
        BIAS_PU_10M:  pull_up_10m[i]    = 1'b1;               // [R10]
        BIAS_PD_500K: pull_down_500k[i] = 1'b1;               // [R10]
        default: ;                                            // [R10]
      endcase
    end
  end

  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    tei_event_input u_input (
      .clock                (clock),
      .rst                  (rst),
      .event_trigger_pin    (event_trigger_pin[g]),
      .event_pin_enable     (enables[EN_PIN_LSB + g]),        // [R09]
      .event_capture_enable (enables[EN_CAP_LSB + g]),        // [R07]
      .edge_polarity_select (cfg[g][CFG_EDGE_MSB:CFG_EDGE_LSB]),
      .trigger              (event_trigger[g]),
      .capture              (capture_strobe[g])
    );
  end

endmodule : tei_regs
`default_nettype wire

// >>> testbench/tei_regs_sva.sv
// Port checker for the event input register bank
`timescale 1ns/10ps
`default_nettype none
module tei_regs_sva (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [2:0]  event_trigger_pin,
  input wire logic [2:0]  event_trigger,
  input wire logic [2:0]  capture_strobe
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // New level crossed both sync stages before the trigger fired
  sequence pin_moved;
    $past(event_trigger_pin[0], 3) != $past(event_trigger_pin[0], 4);
  endsequence
  w_answer_a: assert property (
    both_taken ##0 !s_axi_bvalid |-> ##2 s_axi_bvalid)
    else $error("write answer missing");
  w_busy_a: assert property (
    both_taken |=> !s_axi_awready && !s_axi_wready)
    else $error("write channels not held off");
  r_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  r_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  r_upper_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  trig_pulse_a: assert property (
    event_trigger[0] |=> !event_trigger[0])
    else $error("trigger longer than one cycle");
  trig_cause_a: assert property (event_trigger[0] |-> pin_moved)
    else $error("trigger without pin edge");
  cap_gate_a: assert property (
    capture_strobe != 3'h0 |-> (capture_strobe & ~event_trigger) == 3'h0)
    else $error("capture without trigger");
endmodule : tei_regs_sva
bind tei_regs tei_regs_sva u_sva (
  .clock(clock), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .event_trigger_pin(event_trigger_pin), .event_trigger(event_trigger),
  .capture_strobe(capture_strobe));
`default_nettype wire

// >>> testbench/tei_evt_src.sv
// Behavioural source of the three event trigger signals
`timescale 1ns/10ps
`default_nettype none
module tei_evt_src (
  input  wire logic       clock,
  output var  logic [2:0] event_trigger_pin
);
  // Idle high, as a pulled-up line rests between events
  initial event_trigger_pin = 3'h7;
  // The delay lets the source move promptly or slowly
  task automatic drive(input int n, input logic v, input int dly);
    repeat (dly) @(posedge clock);
    event_trigger_pin[n] <= v;
  endtask : drive
endmodule : tei_evt_src
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the event input register bank
`timescale 1ns/10ps
`default_nettype none
module testbench
  import tei_pkg::*;
;
  logic              clock, rst, bmode;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, rv;
  logic [1:0]        bresp, rresp, resp;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [2:0]        pin, trg, cap, pu5, pu1, pu10, pd5;
  logic [7:0]        seed, d;
  logic [7:0]        mdl [7];
  logic [7:0]        mt [7] = '{MASK_SEC, MASK_MIN, MASK_HOUR, MASK_WEEK,
                                MASK_DAY, MASK_MONTH, MASK_YEAR};
  int                n_errors, check_count, e;
  int                ntrig [3];
  int                ncap [3];

  tei_regs #(.FRAC_TICK_CYCLES(64)) DUT (
    .clock(clock), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .event_trigger_pin(pin),
    .event_trigger(trg), .capture_strobe(cap),
    .buffer_mode_select(bmode), .pull_up_500k(pu5), .pull_up_1m(pu1),
    .pull_up_10m(pu10), .pull_down_500k(pd5));
  tei_evt_src src (.clock(clock), .event_trigger_pin(pin));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Upper data bytes carry noise, so ignored bits are really exercised
  task automatic wr(input logic [6:0] i, input logic [7:0] v);
    @(posedge clock);
    awaddr  <= {3'h0, i, 2'h0};
    wdata   <= {~v, seed, ~v, v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    resp = bresp;
  endtask : wr

  task automatic rd(input logic [6:0] i);
    @(posedge clock);
    araddr  <= {3'h0, i, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    rv = rdata;
    resp = rresp;
  endtask : rd

  task automatic report_and_stop();
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock)
    for (int k = 0; k < 3; k++) begin
      if (trg[k] === 1'b1) ntrig[k]++;
      if (cap[k] === 1'b1) ncap[k]++;
    end

  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    report_and_stop();
  end

  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata} = '0;
    seed = 8'h58;
    repeat (16) @(posedge clock);
    chk(32'(pu1), 32'h7);
    rst <= 1'b0;
    for (int n = 0; n < 3; n++) begin
      rd(IDX_CFG1 + 7'(2 * n));
      chk(rv, 32'h8);
    end
    rd(7'h07);
    chk({rv[29:0], resp}, 32'(RESP_SLVERR));
    wr(7'h07, 8'hff);
    chk(32'(resp), 32'(RESP_SLVERR));
    for (int i = 0; i < 7; i++) begin
      seed = lfsr(seed);
      wr(IDX_SEC_AL + 7'(i), seed);
      mdl[i] = seed & mt[i];
      rd(7'(i));
      chk(rv, 32'(mdl[i]));
      chk(32'(resp), 32'(RESP_OKAY));
      seed = lfsr(seed);
      wr(7'(i), seed);
      chk(32'(resp), 32'(RESP_OKAY));
      mdl[i] = seed & mt[i];
      rd(IDX_SEC_AL + 7'(i));
      chk(rv, 32'(mdl[i]));
    end
    // A known non-zero count makes a missing clear visible
    wr(IDX_SUB_HI, 8'h55);
    wr(IDX_SEC, 8'h12);
    rd(IDX_SUB_HI);
    chk(rv, 32'h0);
    wr(IDX_SUB_LO, 8'hff);
    rd(IDX_SUB_LO);
    chk(rv, 32'hc0);
    repeat (280) @(posedge clock);
    wr(IDX_SEC_AL, 8'h34);
    rd(IDX_SUB_HI);
    chk(rv, 32'h1);
    rd(IDX_SEC);
    chk(rv, 32'h34);
    d = lfsr(seed);
    repeat (2) begin
      wr(IDX_EN, d);
      rd(IDX_EN);
      chk(rv, 32'(d & 8'h7f));
      chk(32'(bmode), 32'(d[6]));
      d = d ^ 8'h40;
    end
    wr(IDX_CFG3, 8'hff);
    rd(IDX_CFG3);
    chk(rv, 32'h1f);
    for (int b = 0; b < 8; b++) begin
      wr(IDX_CFG1, 8'(b << 2));
      e = (b >= 1 && b <= 4) ? 1 << (b - 1) : 0;
      chk(32'({pd5[0], pu10[0], pu1[0], pu5[0]}), 32'(e));
    end
    for (int n = 0; n < 3; n++)
      for (int c = 0; c < 3; c++)
        for (int p = 0; p < 4; p++) begin
          d = (c == 1) ? 8'h00 : 8'(1 << n);
          wr(IDX_EN, d | ((c == 2) ? 8'h00 : 8'(8 << n)));
          wr(IDX_CFG1 + 7'(2 * n), 8'h08 | 8'(p));
          ntrig[n] = 0;
          ncap[n] = 0;
          src.drive(n, 1'b0, 1);
          src.drive(n, 1'b1, 10);
          repeat (10) @(posedge clock);
          e = (c == 1) ? 0 : (p < 2) ? 1 : 2;
          chk(32'(ntrig[n]), 32'(e));
          chk(32'(ncap[n]), (c == 0) ? 32'(e) : 32'h0);
        end
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
